// >>> hdl/gst_timer.v
// Gated sixteen bit timer with gate logic, prescaler and capture/compare time base
//
// How it works
// - Toggle mode routes gate through toggling flip-flop
// - Toggle flip-flop held clear while toggle off
// - Go bit arms counting from next gate edge
// - Trailing gate edge clears go, blocks gate
// - Clearing single pulse mode clears go bit
// - Toggle plus single pulse counts one cycle
// - Gate value shows gate path output even with gate disabled
// - Gate falling edge sets flag, enable requests
// - Gate flag sets even with gate disabled
// - Counter wraps to zero, sets overflow flag
// - Overflow request needs on, enable, global
// - Sleep counting only as asynchronous counter
// - Count is capture source and compare base
// - Special trigger clears count, no flag
// - Counter write beats special trigger clear
// - Prescaler divides by one, two, four, eight
// - Sync bit ignored for system clock sources
// - Wide access bit buffers high byte
// - On and gate enable choose counting mode
// - Polarity bit selects active gate level
// - Go bit reads one while waiting
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "gst_map.vh"

module gst_timer
(
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register port
  input wire [11:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  // Gate source, counting clock and system state
  input wire gate_src,
  input wire count_clk_in,
  input wire sleep_mode,
  input wire global_int_enable,
  // Capture/compare unit
  input wire capture_event,
  input wire special_event_trigger,
  input wire [15:0] capture_compare_value,
  output wire [15:0] count_register,
  output wire compare_match,
  output wire [15:0] capture_value,
  // Requests
  output wire overflow_irq,
  output wire gate_irq,
  output wire wake_up
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [15:0] cnt_ff;
  reg [7:0] hi_buf_ff;
  reg [1:0] ps_sel_ff;
  reg sync_byp_ff;
  reg wide_ff;
  reg on_ff;
  reg ge_ff;
  reg gate_polarity_ff;
  reg gtm_ff;
  reg gate_single_pulse_mode_ff;
  reg go_ff;
  reg [4:0] clksel_ff;
  reg ovf_flag_ff;
  reg gate_flag_ff;
  reg ovf_en_ff;
  reg gate_en_ff;
  reg [2:0] ps_cnt_ff;
  reg clk_in_sync1_ff;
  reg clk_in_sync2_ff;
  reg clk_in_prev_ff;
  reg tog_ff;
  reg gate_value_ff;
  reg gate_value_prev_ff;
  reg spm_run_ff;
  reg [7:0] rdata_ff;
  reg [15:0] cap_ff;
  reg match_ff;
  reg ovf_irq_ff;
  reg gate_irq_ff;
  reg wake_ff;

  // ****************************************************************
  // Clock source and prescaler
  // ****************************************************************
  wire sys_src = (clksel_ff == `GST_CS_FOSC4) || (clksel_ff == `GST_CS_FOSC);
  // Async mode only matters for non-system sources; sync bit otherwise ignored
  wire async_mode = sync_byp_ff && !sys_src;
  // Edge of the external counting clock, synchronised except in async mode, or every cycle for system sources
  wire ext_level = async_mode ? clk_in_prev_ff : clk_in_sync2_ff;
  reg ext_rise;
  always @*
  begin
    ext_rise = ext_level && !clk_in_prev_ff;
    if (async_mode)
      ext_rise = count_clk_in && !clk_in_prev_ff;
  end
  wire src_tick = sys_src ? 1'b1 : ext_rise;
  // Sleep stops every source except the unsynchronised counter
  wire src_ok = !sleep_mode || async_mode;

  reg [2:0] ps_mask;
  always @*
  begin
    case (ps_sel_ff)
      `GST_PS_DIV1: ps_mask = `GST_PS_MASK1;
      `GST_PS_DIV2: ps_mask = `GST_PS_MASK2;
      `GST_PS_DIV4: ps_mask = `GST_PS_MASK4;
      default: ps_mask = `GST_PS_MASK8;
    endcase
  end
  wire ps_done = (ps_cnt_ff & ps_mask) == ps_mask;

  // ****************************************************************
  // Gate path
  // ****************************************************************
  wire gate_pol = gate_polarity_ff ? gate_src : !gate_src;
  // Toggle stage: flips on each rising gate edge, cleared while toggle is off
  wire gate_pol_prev;
  reg gate_pol_d_ff;
  assign gate_pol_prev = gate_pol_d_ff;
  wire gate_rise = gate_pol && !gate_pol_prev;
  wire tog_out = gtm_ff ? tog_ff : gate_pol;
  // Single pulse stage gates the toggle output; together they span one cycle
  wire nxt_gate_value = gate_single_pulse_mode_ff ? (tog_out && (spm_run_ff || go_ff)) : tog_out;
  wire gate_value_fall = gate_value_prev_ff && !gate_value_ff;
  wire gate_value_rise = gate_value_ff && !gate_value_prev_ff;
  // Trailing edge of acquired pulse ends acquisition
  wire spm_end = gate_single_pulse_mode_ff && spm_run_ff && gate_value_fall;

  // Counting enable
  wire gate_active = gate_single_pulse_mode_ff ? (spm_run_ff && gate_value_ff) : gate_value_ff;
  wire cnt_en = on_ff && (!ge_ff || gate_active);
  wire inc = cnt_en && src_tick && src_ok && ps_done;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire wr_lo = reg_wr && (reg_addr == `GST_ADDR_CNT_LO);
  wire wr_hi = reg_wr && (reg_addr == `GST_ADDR_CNT_HI);
  wire wr_ctrl = reg_wr && (reg_addr == `GST_ADDR_CTRL);
  wire wr_gc = reg_wr && (reg_addr == `GST_ADDR_GCTRL);
  wire wr_cs = reg_wr && (reg_addr == `GST_ADDR_CLKSEL);
  wire wr_int = reg_wr && (reg_addr == `GST_ADDR_INT);
  wire rd_lo = reg_rd && (reg_addr == `GST_ADDR_CNT_LO);

  // ****************************************************************
  // Counter
  // ****************************************************************
  reg [15:0] nxt_cnt;
  always @*
  begin
    nxt_cnt = cnt_ff;
    if (inc)
      nxt_cnt = cnt_ff + `GST_ONE16;
    if (special_event_trigger)
      nxt_cnt = `GST_ZERO16;
    // Writes come last so they win over the special trigger clear
    if (wr_lo)
      nxt_cnt = wide_ff ? {hi_buf_ff, reg_wdata} : {cnt_ff[15:8], reg_wdata};
    if (wr_hi && !wide_ff)
      nxt_cnt = {reg_wdata, nxt_cnt[7:0]};
  end
  // Overflow only from a real increment, never from the trigger clear
  wire ovf = inc && (cnt_ff == `GST_MAX16) && !special_event_trigger && !wr_lo && !wr_hi;

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt_ff <= `GST_ZERO16;
      hi_buf_ff <= `GST_ZERO8;
      ps_cnt_ff <= `GST_ZERO3;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      // Buffer: latched on low read, loaded by high write in wide mode
      if (rd_lo && wide_ff)
        hi_buf_ff <= cnt_ff[15:8];
      else if (wr_hi && wide_ff)
        hi_buf_ff <= reg_wdata;
      // Prescaler cleared by low byte write or while the timer is off
      if (wr_lo || !on_ff)
        ps_cnt_ff <= `GST_ZERO3;
      else if (cnt_en && src_tick && src_ok)
        ps_cnt_ff <= ps_cnt_ff + `GST_ONE3;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      ps_sel_ff <= `GST_PS_DIV1;
      sync_byp_ff <= 1'b0;
      wide_ff <= 1'b0;
      on_ff <= 1'b0;
      ge_ff <= 1'b0;
      gate_polarity_ff <= 1'b0;
      gtm_ff <= 1'b0;
      gate_single_pulse_mode_ff <= 1'b0;
      clksel_ff <= `GST_ZERO5;
      ovf_en_ff <= 1'b0;
      gate_en_ff <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ps_sel_ff <= reg_wdata[`GST_CTRL_PS_HI:`GST_CTRL_PS_LO];
        sync_byp_ff <= reg_wdata[`GST_CTRL_SYNC];
        wide_ff <= reg_wdata[`GST_CTRL_WIDE];
        on_ff <= reg_wdata[`GST_CTRL_ON];
      end
      if (wr_gc)
      begin
        ge_ff <= reg_wdata[`GST_GC_GE];
        gate_polarity_ff <= reg_wdata[`GST_GC_GATE_POLARITY];
        gtm_ff <= reg_wdata[`GST_GC_GTM];
        gate_single_pulse_mode_ff <= reg_wdata[`GST_GC_GATE_SINGLE_PULSE_MODE];
      end
      if (wr_cs)
        clksel_ff <= reg_wdata[4:0];
      if (wr_int)
      begin
        ovf_en_ff <= reg_wdata[`GST_INT_OVF_EN];
        gate_en_ff <= reg_wdata[`GST_INT_GATE_EN];
      end
    end
  end

  // ****************************************************************
  // Gate state: toggle, go bit, gate value, flags
  // ****************************************************************
  wire gate_single_pulse_mode_clr = wr_gc && !reg_wdata[`GST_GC_GATE_SINGLE_PULSE_MODE];
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      gate_pol_d_ff <= 1'b0;
      tog_ff <= 1'b0;
      go_ff <= 1'b0;
      spm_run_ff <= 1'b0;
      gate_value_ff <= 1'b0;
      gate_value_prev_ff <= 1'b0;
      ovf_flag_ff <= 1'b0;
      gate_flag_ff <= 1'b0;
    end
    else
    begin
      gate_pol_d_ff <= gate_pol;
      if (!gtm_ff)
        tog_ff <= 1'b0;
      else if (gate_rise)
        tog_ff <= !tog_ff;
      gate_value_ff <= nxt_gate_value;
      gate_value_prev_ff <= gate_value_ff;
      // Go bit: set by software, cleared at pulse end or when mode is left
      if (gate_single_pulse_mode_clr)
        go_ff <= 1'b0;
      else if (wr_gc && reg_wdata[`GST_GC_GO] && reg_wdata[`GST_GC_GATE_SINGLE_PULSE_MODE])
        go_ff <= 1'b1;
      else if (spm_end)
        go_ff <= 1'b0;
      // Run window opens at the gate edge after go, closes at the trailing edge
      if (gate_single_pulse_mode_clr || spm_end)
        spm_run_ff <= 1'b0;
      else if (go_ff && gate_value_rise)
        spm_run_ff <= 1'b1;
      // Flags: hardware set wins over software clear (write 0 clears)
      if (gate_value_fall)
        gate_flag_ff <= 1'b1;
      else if (wr_int && !reg_wdata[`GST_INT_GATE_FLAG])
        gate_flag_ff <= 1'b0;
      if (ovf)
        ovf_flag_ff <= 1'b1;
      else if (wr_int && !reg_wdata[`GST_INT_OVF_FLAG])
        ovf_flag_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Clock input sampling, capture/compare, requests, read data
  // ****************************************************************
  reg [7:0] nxt_rdata;
  always @*
  begin
    case (reg_addr)
      `GST_ADDR_CNT_LO: nxt_rdata = cnt_ff[7:0];
      `GST_ADDR_CNT_HI: nxt_rdata = wide_ff ? hi_buf_ff : cnt_ff[15:8];
      `GST_ADDR_CTRL: nxt_rdata = {2'b00, ps_sel_ff, 1'b0, sync_byp_ff, wide_ff, on_ff};
      `GST_ADDR_GCTRL: nxt_rdata = {ge_ff, gate_polarity_ff, gtm_ff, gate_single_pulse_mode_ff, go_ff, gate_value_ff, 2'b00};
      `GST_ADDR_CLKSEL: nxt_rdata = {3'b000, clksel_ff};
      `GST_ADDR_INT: nxt_rdata = {4'h0, gate_en_ff, ovf_en_ff, gate_flag_ff, ovf_flag_ff};
      default: nxt_rdata = `GST_ZERO8;
    endcase
  end

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      clk_in_sync1_ff <= 1'b0;
      clk_in_sync2_ff <= 1'b0;
      clk_in_prev_ff <= 1'b0;
      cap_ff <= `GST_ZERO16;
      match_ff <= 1'b0;
      ovf_irq_ff <= 1'b0;
      gate_irq_ff <= 1'b0;
      wake_ff <= 1'b0;
      rdata_ff <= `GST_ZERO8;
    end
    else
    begin
      // Two-stage sampler for the synchronised mode
      clk_in_sync1_ff <= count_clk_in;
      clk_in_sync2_ff <= clk_in_sync1_ff;
      clk_in_prev_ff <= async_mode ? count_clk_in : clk_in_sync2_ff;
      if (capture_event)
        cap_ff <= cnt_ff;
      match_ff <= (capture_compare_value == cnt_ff);
      ovf_irq_ff <= ovf_flag_ff && on_ff && ovf_en_ff && global_int_enable;
      gate_irq_ff <= gate_flag_ff && gate_en_ff;
      wake_ff <= sleep_mode && async_mode && ovf_flag_ff && on_ff && ovf_en_ff;
      rdata_ff <= reg_rd ? nxt_rdata : `GST_ZERO8;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_ff;
  assign count_register = cnt_ff;
  assign compare_match = match_ff;
  assign capture_value = cap_ff;
  assign overflow_irq = ovf_irq_ff;
  assign gate_irq = gate_irq_ff;
  assign wake_up = wake_ff;

endmodule

// >>> shared/gst_map.vh
// Register map, field positions and reset values of the gated sixteen bit timer
`ifndef GST_MAP_VH
`define GST_MAP_VH
// Register byte addresses (12-bit register address port)
`define GST_ADDR_CNT_LO 12'h020C
`define GST_ADDR_CNT_HI 12'h020D
`define GST_ADDR_CTRL 12'h020E
`define GST_ADDR_GCTRL 12'h020F
`define GST_ADDR_CLKSEL 12'h0211
`define GST_ADDR_INT 12'h0220
// Control register fields
`define GST_CTRL_ON 0
`define GST_CTRL_WIDE 1
`define GST_CTRL_SYNC 2
`define GST_CTRL_PS_HI 5
`define GST_CTRL_PS_LO 4
// Gate control register fields
`define GST_GC_GE 7
`define GST_GC_GATE_POLARITY 6
`define GST_GC_GTM 5
`define GST_GC_GATE_SINGLE_PULSE_MODE 4
`define GST_GC_GO 3
`define GST_GC_GATE_VALUE 2
// Interrupt register fields
`define GST_INT_OVF_FLAG 0
`define GST_INT_GATE_FLAG 1
`define GST_INT_OVF_EN 2
`define GST_INT_GATE_EN 3
// Clock source codes that are system clock based
`define GST_CS_FOSC4 5'h01
`define GST_CS_FOSC 5'h02
// Reset values and constants
`define GST_ZERO8 8'h00
`define GST_ZERO16 16'h0000
`define GST_MAX16 16'hFFFF
`define GST_ONE16 16'h0001
`define GST_ONE3 3'h1
`define GST_ZERO3 3'h0
`define GST_ZERO5 5'h00
`define GST_PS_DIV1 2'h0
`define GST_PS_DIV2 2'h1
`define GST_PS_DIV4 2'h2
`define GST_PS_MASK1 3'h0
`define GST_PS_MASK2 3'h1
`define GST_PS_MASK4 3'h3
`define GST_PS_MASK8 3'h7
`endif

// >>> bench/gst_partner.sv
// Far-side model: gate source, counting clock and capture/compare unit
`timescale 1ns/1ps

module gst_partner
(
  // Clock
  input wire clk,
  // Commands from the bench
  input wire gate_run,
  input wire gate_idle,
  input wire [7:0] gate_half,
  input wire sev_en,
  input wire sev_req,
  input wire cap_req,
  // Feedback from the timer
  input wire compare_match,
  // Drives into the timer
  output reg gate_src,
  output reg count_clk_in,
  output wire special_event_trigger,
  output wire capture_event
);
  reg [7:0] half_ff;

  // Gate wave; a stopped gate rests at the idle level so no stray edges appear
  initial
  begin
    gate_src = 1'b0;
    count_clk_in = 1'b0;
    half_ff = 8'h00;
  end
  always @(posedge clk)
  begin
    count_clk_in <= ~count_clk_in;
    if (!gate_run)
    begin
      half_ff <= 8'h00;
      gate_src <= gate_idle;
    end
    else if (half_ff == gate_half - 8'h01)
    begin
      half_ff <= 8'h00;
      gate_src <= ~gate_src;
    end
    else
      half_ff <= half_ff + 8'h01;
  end

  // Compare match in special event mode clears the timer
  assign special_event_trigger = (sev_en & compare_match) | sev_req;
  assign capture_event = cap_req;
endmodule

// >>> bench/gst_timer_checker.sv
// Port-level assertions for the gated sixteen bit timer
`timescale 1ns/1ps
`include "gst_map.vh"

module gst_timer_checker
(
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Watched ports
  input wire [11:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire sleep_mode,
  input wire global_int_enable,
  input wire capture_event,
  input wire special_event_trigger,
  input wire [15:0] capture_compare_value,
  input wire [15:0] count_register,
  input wire compare_match,
  input wire [15:0] capture_value,
  input wire overflow_irq,
  input wire wake_up
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire cnt_wr;
  wire mapped;

  // Decodes; a counter write outranks a trigger, so it is excluded below
  assign cnt_wr = reg_wr && (reg_addr == `GST_ADDR_CNT_LO || reg_addr == `GST_ADDR_CNT_HI);
  assign mapped = reg_addr == `GST_ADDR_CNT_LO || reg_addr == `GST_ADDR_CNT_HI ||
    reg_addr == `GST_ADDR_CTRL || reg_addr == `GST_ADDR_GCTRL ||
    reg_addr == `GST_ADDR_CLKSEL || reg_addr == `GST_ADDR_INT;
  sequence unmapped_rd_s;
    reg_rd && !mapped;
  endsequence
  sequence plain_cycle_s;
    !reg_wr && !special_event_trigger;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == `GST_ZERO8)
    else $error("read data not zero outside read slot");
  unmapped_read_a: assert property (unmapped_rd_s |=> reg_rdata == `GST_ZERO8)
    else $error("unmapped read returned data");
  count_step_a: assert property (plain_cycle_s |=> count_register == $past(count_register) ||
    count_register == $past(count_register) + `GST_ONE16) else $error("counter jumped");
  sev_clear_a: assert property (special_event_trigger && !cnt_wr |=> count_register == `GST_ZERO16)
    else $error("trigger did not clear counter");
  capture_copy_a: assert property (capture_event |=> capture_value == $past(count_register))
    else $error("capture value wrong");
  compare_match_a: assert property (1'b1 |=>
    compare_match == ($past(capture_compare_value) == $past(count_register)))
    else $error("compare match wrong");
  ovf_global_a: assert property (!global_int_enable |=> !overflow_irq)
    else $error("overflow request without global enable");
  wake_sleep_a: assert property (!sleep_mode |=> !wake_up)
    else $error("wake-up outside sleep");
endmodule

bind gst_timer gst_timer_checker i_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
  .global_int_enable(global_int_enable), .capture_event(capture_event),
  .special_event_trigger(special_event_trigger), .capture_compare_value(capture_compare_value),
  .count_register(count_register), .compare_match(compare_match),
  .capture_value(capture_value), .overflow_irq(overflow_irq), .wake_up(wake_up));

// >>> bench/test_gst_timer.sv
// Self-checking testbench of the gated sixteen bit timer
`timescale 1ns/1ps
`include "gst_map.vh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s expected %h seen %h", nm, e, g); end end

module test_gst_timer;
  reg clk, rstn, reg_wr, reg_rd, sleep_mode, global_int_enable;
  reg gate_run, gate_idle, sev_en, sev_req, cap_req;
  reg [11:0] reg_addr;
  reg [7:0] reg_wdata, gate_half, d;
  reg [15:0] ccv, c;
  wire [7:0] reg_rdata;
  wire [15:0] count_register, capture_value;
  wire gate_src, count_clk_in, special_event_trigger, capture_event, compare_match;
  wire overflow_irq, gate_irq, wake_up;
  integer n_fail, tests_run, cyc, i;

  gst_timer i_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gate_src(gate_src),
    .count_clk_in(count_clk_in), .sleep_mode(sleep_mode), .global_int_enable(global_int_enable),
    .capture_event(capture_event), .special_event_trigger(special_event_trigger),
    .capture_compare_value(ccv), .count_register(count_register), .compare_match(compare_match),
    .capture_value(capture_value), .overflow_irq(overflow_irq), .gate_irq(gate_irq),
    .wake_up(wake_up));
  gst_partner i_far (.clk(clk), .gate_run(gate_run), .gate_idle(gate_idle),
    .gate_half(gate_half), .sev_en(sev_en), .sev_req(sev_req), .cap_req(cap_req),
    .compare_match(compare_match), .gate_src(gate_src), .count_clk_in(count_clk_in),
    .special_event_trigger(special_event_trigger), .capture_event(capture_event));

  // ****************************************
  // Clock, watchdog and register access
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog well above the roughly seven hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test;
    end
  end
  task wr(input [11:0] a, input [7:0] v);
  begin
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  end
  endtask
  task rd(input [11:0] a);
  begin
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  end
  endtask
  task stop_test;
  begin
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rstn, reg_wr, reg_rd, sleep_mode, global_int_enable, gate_run, gate_idle} = 7'h00;
    {sev_en, sev_req, cap_req, reg_addr, reg_wdata, ccv} = 0;
    gate_half = 8'h0A; n_fail = 0; tests_run = 0; cyc = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(`GST_ADDR_CTRL); `CHK("control reset", 8'h00, d)
    rd(`GST_ADDR_GCTRL); `CHK("gate control reset", 8'h00, d & 8'hFB)
    rd(`GST_ADDR_INT); `CHK("interrupt reset", 8'h00, d)
    rd(12'h0210); `CHK("unmapped read", 8'h00, d)
    // Count on the system clock so every cycle is a tick
    wr(`GST_ADDR_CLKSEL, 8'h02); rd(`GST_ADDR_CLKSEL); `CHK("clock select", 8'h02, d)
    // Each ratio over the same window; off also clears the prescaler
    for (i = 0; i < 4; i++)
    begin
      wr(`GST_ADDR_CNT_LO, 8'h00); wr(`GST_ADDR_CTRL, {2'b00, i[1:0], 4'h1}); repeat (63) @(posedge clk);
      wr(`GST_ADDR_CTRL, 8'h00);
      `CHK("prescale", 1'b1, count_register >= (64 >> i) - 1 && count_register <= (64 >> i) + 1)
    end
    wr(`GST_ADDR_CNT_HI, 8'hAB); `CHK("narrow high", 8'hAB, count_register[15:8])
    wr(`GST_ADDR_CTRL, 8'h02); wr(`GST_ADDR_CNT_HI, 8'h12); `CHK("buffered high", 8'hAB, count_register[15:8])
    wr(`GST_ADDR_CNT_LO, 8'h34); `CHK("wide write", 16'h1234, count_register)
    rd(`GST_ADDR_CNT_LO); `CHK("wide low", 8'h34, d)
    rd(`GST_ADDR_CNT_HI); `CHK("wide high", 8'h12, d)
    // Overflow: flag cleared and counter loaded with FFFE before the enables go on
    wr(`GST_ADDR_CTRL, 8'h00); wr(`GST_ADDR_INT, 8'h00);
    wr(`GST_ADDR_CNT_LO, 8'hFE); wr(`GST_ADDR_CNT_HI, 8'hFF); wr(`GST_ADDR_INT, 8'h04);
    global_int_enable <= 1'b1; wr(`GST_ADDR_CTRL, 8'h01); repeat (4) @(posedge clk);
    rd(`GST_ADDR_INT); `CHK("overflow flag", 8'h05, d & 8'h0D)
    `CHK("overflow request", 1'b1, overflow_irq)
    global_int_enable <= 1'b0; repeat (2) @(posedge clk); #1 `CHK("masked request", 1'b0, overflow_irq)
    wr(`GST_ADDR_INT, 8'h04); wr(`GST_ADDR_CNT_LO, 8'h00); ccv <= 16'h0010; sev_en <= 1'b1;
    repeat (100) @(posedge clk);
    `CHK("trigger period", 1'b1, count_register <= 16'h0011)
    rd(`GST_ADDR_INT); `CHK("no overflow flag", 8'h00, d & 8'h01)
    sev_en <= 1'b0; wr(`GST_ADDR_CTRL, 8'h00);
    @(posedge clk); sev_req <= 1'b1; reg_wr <= 1'b1; reg_addr <= `GST_ADDR_CNT_LO; reg_wdata <= 8'h55;
    @(posedge clk); sev_req <= 1'b0; reg_wr <= 1'b0;
    #1 `CHK("write over trigger", 16'h0055, count_register)
    @(posedge clk); cap_req <= 1'b1; @(posedge clk); cap_req <= 1'b0;
    #1 `CHK("capture", 16'h0055, capture_value)
    // Gated counting, live gate level and gate events
    wr(`GST_ADDR_GCTRL, 8'hC0); wr(`GST_ADDR_CTRL, 8'h01); repeat (20) @(posedge clk);
    `CHK("gate inactive holds", 16'h0055, count_register)
    gate_idle <= 1'b1; repeat (20) @(posedge clk);
    `CHK("gate active counts", 1'b1, count_register > 16'h0060)
    wr(`GST_ADDR_GCTRL, 8'h40); rd(`GST_ADDR_GCTRL); `CHK("gate value ungated", 8'h04, d & 8'h04)
    gate_idle <= 1'b0; repeat (4) @(posedge clk);
    rd(`GST_ADDR_INT); `CHK("gate flag ungated", 8'h02, d & 8'h02)
    wr(`GST_ADDR_INT, 8'h0A); repeat (2) @(posedge clk); #1 `CHK("gate request", 1'b1, gate_irq)
    wr(`GST_ADDR_INT, 8'h00); repeat (2) @(posedge clk); #1 `CHK("gate request off", 1'b0, gate_irq)
    // Single pulse, then toggle plus single pulse; polarity stays put
    for (i = 0; i < 2; i++)
    begin
      wr(`GST_ADDR_CTRL, 8'h00); wr(`GST_ADDR_CNT_LO, 8'h00); wr(`GST_ADDR_CNT_HI, 8'h00);
      wr(`GST_ADDR_CTRL, 8'h01); wr(`GST_ADDR_GCTRL, i ? 8'hF8 : 8'hD8);
      rd(`GST_ADDR_GCTRL); `CHK("go waiting", 8'h08, d & 8'h08)
      gate_run <= 1'b1; repeat (80) @(posedge clk); gate_run <= 1'b0;
      rd(`GST_ADDR_GCTRL); `CHK("go done", 8'h00, d & 8'h08)
      `CHK("one pulse", 1'b1, count_register >= 10 * i + 8 && count_register <= 10 * i + 12)
      wr(`GST_ADDR_GCTRL, 8'hC0);
    end
    wr(`GST_ADDR_GCTRL, 8'hD8); wr(`GST_ADDR_GCTRL, 8'hC0);
    rd(`GST_ADDR_GCTRL); `CHK("go cleared", 8'h00, d & 8'h08)
    wr(`GST_ADDR_GCTRL, 8'h00); wr(`GST_ADDR_CLKSEL, 8'h02); sleep_mode <= 1'b1;
    #1 c = count_register; repeat (10) @(posedge clk);
    #1 `CHK("sleep stops", c, count_register)
    sleep_mode <= 1'b0;
    stop_test;
  end
endmodule
